// [include/prdt_pkg.sv]
package prdt_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;
    localparam int PRE_W  = 6;
    localparam int SEL_W  = 3;

    localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h4B;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH     = 8'h4C;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LOW      = 8'h4D;
    localparam logic [ADDR_W-1:0] OFS_MODULO_HIGH    = 8'h4E;
    localparam logic [ADDR_W-1:0] OFS_MODULO_LOW     = 8'h4F;

    localparam int BIT_OVERFLOW_FLAG   = 7;
    localparam int BIT_OVERFLOW_IE     = 6;
    localparam int BIT_COUNTER_STOP    = 5;
    localparam int BIT_COUNTER_RESET   = 4;
    localparam int BIT_PRESCALER_SEL_H = 2;
    localparam int BIT_PRESCALER_SEL_L = 0;

    localparam logic                RST_OVERFLOW_FLAG = 1'b0;
    localparam logic                RST_OVERFLOW_IE   = 1'b0;
    localparam logic                RST_COUNTER_STOP  = 1'b1;
    localparam logic                RST_COUNTER_RESET = 1'b0;
    localparam logic [SEL_W-1:0]    RST_PRESCALER_SEL = 3'h0;
    localparam logic [CNT_W-1:0]    RST_COUNT         = 16'h0000;
    localparam logic [DATA_W-1:0]   RST_MODULO_BYTE   = 8'hFF;
    localparam logic [PRE_W-1:0]    RST_PRESCALER     = 6'h00;
    localparam logic [DATA_W-1:0]   RST_READ_DATA     = 8'h00;

    localparam logic [SEL_W-1:0]    SEL_MAX_DIVIDE    = 3'h6;

    typedef enum logic [1:0] {
        PRDT_CLR_IDLE  = 2'b01,
        PRDT_CLR_ARMED = 2'b10
    } prdt_clr_e;

endpackage

// [src/prdt_prescaler.sv]
`timescale 1ns/100ps

module prdt_prescaler (
    input  wire logic                            sys_clk_i,
    input  wire logic                            reset_n_i,
    input  wire logic                            run_i,
    input  wire logic                            clear_i,
    input  wire logic [prdt_pkg::SEL_W-1:0]      select_i,
    output logic                                 tick_o
);

    logic [prdt_pkg::PRE_W-1:0] divider;
    logic [prdt_pkg::PRE_W-1:0] tap_mask;

    // Codes above the largest divide fold onto divide by 64.
    function automatic logic [prdt_pkg::PRE_W-1:0] divide_mask(input logic [prdt_pkg::SEL_W-1:0] sel);
        logic [prdt_pkg::SEL_W-1:0] eff;
        eff = (sel > prdt_pkg::SEL_MAX_DIVIDE) ? prdt_pkg::SEL_MAX_DIVIDE : sel;
        divide_mask = prdt_pkg::PRE_W'((7'h01 << eff) - 7'h01);
    endfunction

    always_comb begin
        tap_mask = divide_mask(select_i);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            divider <= prdt_pkg::RST_PRESCALER;
        end else if (clear_i) begin
            divider <= prdt_pkg::RST_PRESCALER;
        end else if (run_i) begin
            divider <= divider + 6'h01;
        end
    end

    // Tick when all bits below the selected tap are set, so divide by 1 ticks every cycle.
    assign tick_o = run_i && !clear_i && ((divider & tap_mask) == tap_mask);

endmodule // prdt_prescaler

// [src/prdt_timer.sv]
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps


module prdt_timer (
    input  wire logic                            sys_clk_i,
    input  wire logic                            reset_n_i,
    input  wire logic [prdt_pkg::ADDR_W-1:0]     addr_i,
    input  wire logic [prdt_pkg::DATA_W-1:0]     wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic      [prdt_pkg::DATA_W-1:0]     rdata_o,
    input  wire logic                            break_i,
    input  wire logic                            break_clear_permission_i,
    input  wire logic                            stop_mode_i,
    output logic                                 irq_o
);

    logic                               overflow_flag;
    logic                               overflow_interrupt_enable;
    logic                               counter_stop;
    logic                               counter_reset_bit;
    logic [prdt_pkg::SEL_W-1:0]         prescaler_select;
    logic [prdt_pkg::CNT_W-1:0]         count;
    logic [prdt_pkg::DATA_W-1:0]        modulo_high;
    logic [prdt_pkg::DATA_W-1:0]        modulo_low;
    logic                               modulo_pending;
    logic [prdt_pkg::DATA_W-1:0]        low_buffer;
    logic                               low_latched;
    logic [prdt_pkg::DATA_W-1:0]        rdata;
    prdt_pkg::prdt_clr_e                clr_state;
    prdt_pkg::prdt_clr_e                next_clr_state;

    logic                               sel_status;
    logic                               sel_count_high;
    logic                               sel_count_low;
    logic                               sel_modulo_high;
    logic                               sel_modulo_low;
    logic                               wr_status;
    logic                               rd_status;
    logic                               rd_count_high;
    logic                               rd_count_low;
    logic                               wr_modulo_high;
    logic                               wr_modulo_low;
    logic                               guarded;
    logic                               counting;
    logic                               tick;
    logic                               match;
    logic                               overflow_event;
    logic                               clear_request;
    logic                               counter_clear;
    logic [prdt_pkg::CNT_W-1:0]         modulo;
    logic [prdt_pkg::DATA_W-1:0]        status_view;
    logic [prdt_pkg::DATA_W-1:0]        next_rdata;

    function automatic logic hit(input logic [prdt_pkg::ADDR_W-1:0] a,
                                 input logic [prdt_pkg::ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Address decode.

    always_comb begin
        sel_status      = hit(addr_i, prdt_pkg::OFS_STATUS_CONTROL);
        sel_count_high  = hit(addr_i, prdt_pkg::OFS_COUNT_HIGH);
        sel_count_low   = hit(addr_i, prdt_pkg::OFS_COUNT_LOW);
        sel_modulo_high = hit(addr_i, prdt_pkg::OFS_MODULO_HIGH);
        sel_modulo_low  = hit(addr_i, prdt_pkg::OFS_MODULO_LOW);
    end

    assign wr_status      = wr_i && sel_status;
    assign rd_status      = rd_i && sel_status;
    assign rd_count_high  = rd_i && sel_count_high;
    assign rd_count_low   = rd_i && sel_count_low;
    assign wr_modulo_high = wr_i && sel_modulo_high;
    assign wr_modulo_low  = wr_i && sel_modulo_low;

    // Status bits are shielded while in a break unless the integration unit grants clearing.
    assign guarded = break_i && !break_clear_permission_i;

    // Counting engine.

    assign modulo        = {modulo_high, modulo_low};
    assign counting      = !counter_stop && !break_i && !stop_mode_i;
    assign counter_clear = counter_reset_bit;
    assign match         = (count == modulo);
    assign overflow_event = tick && match && !modulo_pending;

    prdt_prescaler u_prescaler (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .run_i     (counting),
        .clear_i   (counter_clear),
        .select_i  (prescaler_select),
        .tick_o    (tick)
    );

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            count <= prdt_pkg::RST_COUNT;
        end else if (counter_clear) begin
            count <= prdt_pkg::RST_COUNT;
        end else if (tick) begin
            if (match) begin
                count <= prdt_pkg::RST_COUNT;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end

    // Reset bit is held for one cycle so the counter clear lands, then drops by itself.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            counter_reset_bit <= prdt_pkg::RST_COUNTER_RESET;
        end else if (wr_status && wdata_i[prdt_pkg::BIT_COUNTER_RESET]) begin
            counter_reset_bit <= 1'b1;
        end else begin
            counter_reset_bit <= 1'b0;
        end
    end

    // Control fields of the status register.

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            overflow_interrupt_enable <= prdt_pkg::RST_OVERFLOW_IE;
            counter_stop              <= prdt_pkg::RST_COUNTER_STOP;
            prescaler_select          <= prdt_pkg::RST_PRESCALER_SEL;
        end else if (wr_status) begin
            overflow_interrupt_enable <= wdata_i[prdt_pkg::BIT_OVERFLOW_IE];
            counter_stop              <= wdata_i[prdt_pkg::BIT_COUNTER_STOP];
            prescaler_select          <= wdata_i[prdt_pkg::BIT_PRESCALER_SEL_H:prdt_pkg::BIT_PRESCALER_SEL_L];
        end
    end

    // Two-step clearing: a status read that sees the flag arms; the zero write then clears.

    always_comb begin
        next_clr_state = clr_state;
        case (clr_state)
            prdt_pkg::PRDT_CLR_IDLE: begin
                if (rd_status && overflow_flag && !guarded) begin
                    next_clr_state = prdt_pkg::PRDT_CLR_ARMED;
                end
            end
            prdt_pkg::PRDT_CLR_ARMED: begin
                if (overflow_event) begin
                    next_clr_state = prdt_pkg::PRDT_CLR_IDLE;
                end else if (wr_status && !guarded) begin
                    next_clr_state = prdt_pkg::PRDT_CLR_IDLE;
                end else if (!overflow_flag) begin
                    next_clr_state = prdt_pkg::PRDT_CLR_IDLE;
                end
            end
            default: begin
                next_clr_state = prdt_pkg::PRDT_CLR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            clr_state <= prdt_pkg::PRDT_CLR_IDLE;
        end else begin
            clr_state <= next_clr_state;
        end
    end

    // A write of one to the flag bit never clears; a write in a shielded break does not clear either.
    assign clear_request = wr_status
                        && !wdata_i[prdt_pkg::BIT_OVERFLOW_FLAG]
                        && (clr_state == prdt_pkg::PRDT_CLR_ARMED)
                        && !guarded;

    // A new overflow in the same cycle as the clearing write wins over the clear.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            overflow_flag <= prdt_pkg::RST_OVERFLOW_FLAG;
        end else if (overflow_event) begin
            overflow_flag <= 1'b1;
        end else if (clear_request) begin
            overflow_flag <= 1'b0;
        end
    end

    // Modulo pair; the high byte write holds off flagging until the low byte follows.

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            modulo_high <= prdt_pkg::RST_MODULO_BYTE;
            modulo_low  <= prdt_pkg::RST_MODULO_BYTE;
        end else begin
            if (wr_modulo_high) begin
                modulo_high <= wdata_i;
            end
            if (wr_modulo_low) begin
                modulo_low <= wdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            modulo_pending <= 1'b0;
        end else if (wr_modulo_low) begin
            modulo_pending <= 1'b0;
        end else if (wr_modulo_high) begin
            modulo_pending <= 1'b1;
        end
    end

    // Low byte buffer of the count; the latch survives a break, so software must unlatch it.

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            low_latched <= 1'b0;
            low_buffer  <= prdt_pkg::RST_COUNT[prdt_pkg::DATA_W-1:0];
        end else if (rd_count_low) begin
            low_latched <= 1'b0;
        end else if (rd_count_high && !low_latched) begin
            low_latched <= 1'b1;
            low_buffer  <= count[prdt_pkg::DATA_W-1:0];
        end
    end

    // Read path; the reset bit always reads zero and bit three reads zero.

    always_comb begin
        status_view                                    = prdt_pkg::RST_READ_DATA;
        status_view[prdt_pkg::BIT_OVERFLOW_FLAG]       = overflow_flag;
        status_view[prdt_pkg::BIT_OVERFLOW_IE]         = overflow_interrupt_enable;
        status_view[prdt_pkg::BIT_COUNTER_STOP]        = counter_stop;
        status_view[prdt_pkg::BIT_COUNTER_RESET]       = 1'b0;
        status_view[prdt_pkg::BIT_PRESCALER_SEL_H:prdt_pkg::BIT_PRESCALER_SEL_L] = prescaler_select;
    end

    always_comb begin
        next_rdata = prdt_pkg::RST_READ_DATA;
        if (rd_i) begin
            if (sel_status) begin
                next_rdata = status_view;
            end else if (sel_count_high) begin
                next_rdata = count[prdt_pkg::CNT_W-1:prdt_pkg::DATA_W];
            end else if (sel_count_low) begin
                next_rdata = low_latched ? low_buffer : count[prdt_pkg::DATA_W-1:0];
            end else if (sel_modulo_high) begin
                next_rdata = modulo_high;
            end else if (sel_modulo_low) begin
                next_rdata = modulo_low;
            end
        end
    end

    // Read data stands only in the cycle after the read strobe; unmapped reads return zero.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            rdata <= prdt_pkg::RST_READ_DATA;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign rdata_o = rdata;

    // The request is not gated by wait mode, so it can wake the processor.
    assign irq_o = overflow_flag && overflow_interrupt_enable && !modulo_pending;

endmodule // prdt_timer

// [test/prdt_timer_checker.sv]
`timescale 1ns/100ps

module prdt_timer_checker (
    input  wire logic                            sys_clk_i,
    input  wire logic                            reset_n_i,
    input  wire logic [prdt_pkg::ADDR_W-1:0]     addr_i,
    input  wire logic [prdt_pkg::DATA_W-1:0]     wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    input  wire logic [prdt_pkg::DATA_W-1:0]     rdata_o,
    input  wire logic                            break_i,
    input  wire logic                            break_clear_permission_i,
    input  wire logic                            stop_mode_i,
    input  wire logic                            irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    rdata_idle_a: assert property (rdata_o != 8'h00 |-> $past(rd_i))
        else $error("read data outside a read answer");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n_i |=> !irq_o && rdata_o == 8'h00)
        else $error("outputs not quiet after reset");
    reset_bit_zero_a: assert property ($past(rd_i && addr_i == prdt_pkg::OFS_STATUS_CONTROL) |-> rdata_o[4:3] == 2'h0)
        else $error("counter reset bit reads as one");
    irq_enable_off_a: assert property ($past(wr_i && addr_i == prdt_pkg::OFS_STATUS_CONTROL && !wdata_i[6]) |-> !irq_o)
        else $error("request raised with enable cleared");
    irq_flag_seen_a: assert property ($past(rd_i && addr_i == prdt_pkg::OFS_STATUS_CONTROL && irq_o) |-> rdata_o[7:6] == 2'h3)
        else $error("request raised without flag and enable");
    modulo_hold_a: assert property ((wr_i && addr_i == prdt_pkg::OFS_MODULO_HIGH) ##1
        !(wr_i && addr_i == prdt_pkg::OFS_MODULO_LOW) |-> !irq_o ##1 !irq_o)
        else $error("request raised while modulo half written");
    modulo_readback_a: assert property ((wr_i && addr_i == prdt_pkg::OFS_MODULO_LOW) ##1
        (rd_i && addr_i == prdt_pkg::OFS_MODULO_LOW) |=> rdata_o == $past(wdata_i, 2))
        else $error("modulo low byte does not read back");
    select_readback_a: assert property ((wr_i && addr_i == prdt_pkg::OFS_STATUS_CONTROL) ##1
        (rd_i && addr_i == prdt_pkg::OFS_STATUS_CONTROL) |=> rdata_o[6:0] == {$past(wdata_i[6:5], 2), 2'h0,
        $past(wdata_i[2:0], 2)})
        else $error("status fields do not read back");
endmodule // prdt_timer_checker

// [test/test_prdt_timer.sv]
`timescale 1ns/100ps

module test_prdt_timer;
    logic       sys_clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic [7:0] addr_i    = 8'h00;
    logic [7:0] wdata_i   = 8'h00;
    logic       wr_i      = 1'b0;
    logic       rd_i      = 1'b0;
    logic [7:0] rdata_o;
    logic       break_i   = 1'b0;
    logic       perm_i    = 1'b0;
    logic       stop_mode_i = 1'b0;
    logic       irq_o;
    int         n_mismatch = 0;
    int         n_compared = 0;

    prdt_timer prdt_timer_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .break_i(break_i), .break_clear_permission_i(perm_i),
        .stop_mode_i(stop_mode_i), .irq_o(irq_o));

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each write ends a little past its taking edge so that its effects have landed.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask

    // A write with the read right behind it, the only way the readback assertions get exercised.
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input string name);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        check(name, rdata_o, d);
    endtask

    task automatic ci(input logic exp);
        check("irq", {7'h00, irq_o}, {7'h00, exp});
    endtask

    task automatic get_flag();
        int i;
        wr(8'h4B, 8'h50);
        for (i = 0; i < 20 && irq_o !== 1'b1; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        if (irq_o !== 1'b1) begin
            n_mismatch++;
            close_out();
        end
        wr(8'h4B, 8'h60);
    endtask

    task automatic reset_values();
        rdc(8'h4B, 8'h20, "status");
        rdc(8'h4C, 8'h00, "count high");
        rdc(8'h4E, 8'hFF, "modulo high");
        rdc(8'h4F, 8'hFF, "modulo low");
        rdc(8'h50, 8'h00, "unmapped");
        wr(8'h4C, 8'hFF);
        rdc(8'h4C, 8'h00, "count high");
        wr_rd(8'h4F, 8'h5A, "modulo low");
        wr_rd(8'h4B, 8'h27, "status");
    endtask

    // Each select runs exactly three divider periods, so the expected count is phase independent.
    task automatic prescaler();
        int s;
        int div;
        for (s = 0; s < 8; s++) begin
            div = (s == 7) ? 64 : (1 << s);
            wr(8'h4B, 8'h30 | 8'(s));
            rdc(8'h4D, 8'h00, "count low");
            wr(8'h4B, 8'h10 | 8'(s));
            repeat (3 * div - 1) @(posedge sys_clk_i);
            wr(8'h4B, 8'h20 | 8'(s));
            rdc(8'h4D, 8'h03, "count low");
            rdc(8'h4B, 8'h20 | 8'(s), "status");
        end
    endtask

    task automatic flag_clear();
        logic [7:0] d;
        wr(8'h4B, 8'h30);
        wr(8'h4E, 8'h00);
        wr(8'h4F, 8'h04);
        get_flag();
        wr(8'h4B, 8'hE0);
        rdc(8'h4B, 8'hE0, "status");
        wr(8'h4B, 8'hE0);
        wr(8'h4B, 8'h60);
        ci(1'b1);
        rd(8'h4B, d);
        wr(8'h4B, 8'h60);
        ci(1'b0);
        get_flag();
        wr(8'h4B, 8'h40);
        rd(8'h4B, d);
        repeat (10) @(posedge sys_clk_i);
        wr(8'h4B, 8'h60);
        ci(1'b1);
        wr(8'h4B, 8'h20);
        ci(1'b0);
        wr(8'h4B, 8'h60);
        ci(1'b1);
        wr(8'h4E, 8'h00);
        ci(1'b0);
        wr(8'h4F, 8'h04);
        ci(1'b1);
    endtask

    task automatic freeze_modes();
        logic [7:0] a;
        logic [7:0] b;
        int m;
        wr(8'h4E, 8'hFF);
        wr(8'h4F, 8'hFF);
        wr(8'h4B, 8'h10);
        for (m = 0; m < 2; m++) begin
            @(posedge sys_clk_i);
            break_i <= (m == 0);
            stop_mode_i <= (m == 1);
            rd(8'h4D, a);
            repeat (5) @(posedge sys_clk_i);
            rdc(8'h4D, a, "frozen count");
            @(posedge sys_clk_i);
            break_i <= 1'b0;
            stop_mode_i <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
            rd(8'h4D, b);
            check("resumed", {7'h00, b == a}, 8'h00);
        end
    endtask

    task automatic latch();
        logic [7:0] d;
        wr(8'h4B, 8'h30);
        wr(8'h4B, 8'h00);
        repeat (20) @(posedge sys_clk_i);
        wr(8'h4B, 8'h20);
        rdc(8'h4D, 8'h16, "count low");
        rd(8'h4C, d);
        wr(8'h4B, 8'h00);
        repeat (20) @(posedge sys_clk_i);
        wr(8'h4B, 8'h20);
        rd(8'h4C, d);
        rdc(8'h4D, 8'h16, "latched low");
        rdc(8'h4D, 8'h2C, "live low");
    endtask

    task automatic break_flag();
        logic [7:0] d;
        wr(8'h4B, 8'h30);
        wr(8'h4E, 8'h00);
        wr(8'h4F, 8'h04);
        get_flag();
        rd(8'h4B, d);
        @(posedge sys_clk_i);
        break_i <= 1'b1;
        rd(8'h4B, d);
        wr(8'h4B, 8'h60);
        ci(1'b1);
        @(posedge sys_clk_i);
        break_i <= 1'b0;
        wr(8'h4B, 8'h60);
        ci(1'b0);
        get_flag();
        @(posedge sys_clk_i);
        break_i <= 1'b1;
        perm_i <= 1'b1;
        rd(8'h4B, d);
        wr(8'h4B, 8'h60);
        ci(1'b0);
        @(posedge sys_clk_i);
        break_i <= 1'b0;
        perm_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        ci(1'b0);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        reset_values();
        prescaler();
        flag_clear();
        freeze_modes();
        latch();
        break_flag();
        close_out();
    end
endmodule // test_prdt_timer

bind prdt_timer prdt_timer_checker prdt_timer_checker_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .break_i(break_i),
    .break_clear_permission_i(break_clear_permission_i), .stop_mode_i(stop_mode_i), .irq_o(irq_o));
